/* dtc_defines.vh */
// Purpose: constants for the dual timer/counter block
// Assumes: wishbone word addressing, byte data in bits 7:0
// Notes: byte address is four times the printed index
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
// register indices
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_TL0 8'h8a
`define DTC_IDX_TL1 8'h8b
`define DTC_IDX_TH0 8'h8c
`define DTC_IDX_TH1 8'h8d
`define DTC_IDX_AUX 8'h8f
`define DTC_IDX_TOG 8'ha2
`define DTC_IDX_ISTAT 8'ha3
`define DTC_IDX_IMASK 8'ha4
// mode select fields
`define DTC_T0_MODE_LO 0
`define DTC_T0_FUNC 2
`define DTC_T0_GATE 3
`define DTC_T1_MODE_LO 4
`define DTC_T1_FUNC 6
`define DTC_T1_GATE 7
// aux mode fields
`define DTC_T0_MODE_B2 0
`define DTC_T1_MODE_B2 4
`define DTC_AUX_MASK 8'h11
// control fields
`define DTC_T0_RUN 4
`define DTC_T0_FLAG 5
`define DTC_T1_RUN 6
`define DTC_T1_FLAG 7
// mode codes
`define DTC_MODE_13 3'h0
`define DTC_MODE_16 3'h1
`define DTC_MODE_RELOAD 3'h2
`define DTC_MODE_SPLIT 3'h3
`define DTC_MODE_PWM 3'h6
// reset values
`define DTC_RST_BYTE 8'h00
// machine cycle = two cpu clocks
`define DTC_MC_CLKS 2
`endif

/* dtc_edge_det.v */
// Purpose: sync a count pin and flag falling edges per machine cycle
// Assumes: mc_tick_i pulses once per machine cycle
// Notes: two flops before any logic reads the pin
`timescale 1ns/1ps
`default_nettype none
module dtc_edge_det
(
    input wire clk_i,
    input wire rst_i,
    input wire pin_i,
    input wire mc_tick_i,
    output reg fall_o
);
    reg meta_q;
    reg sync_q;
    reg samp_q;
    reg prev_q;
    // synchroniser, then one sample per machine cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            samp_q <= 1'b1;
            prev_q <= 1'b1;
            fall_o <= 1'b0;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            fall_o <= 1'b0;
            if (mc_tick_i)
            begin
                samp_q <= sync_q;
                prev_q <= samp_q;
                fall_o <= prev_q & ~samp_q;
            end
        end
    end
endmodule
`default_nettype wire

/* dtc_pins.sv */
// Purpose: stand-in for the count and gate pins outside the block
// Assumes: levels change just after a rising edge
// Notes: a driven count pin wins over the external source
`timescale 1ns/1ps
`default_nettype none
module dtc_pins
(
    input wire logic clk_i,
    input wire logic drv0_i,
    input wire logic oe0_i,
    input wire logic drv1_i,
    input wire logic oe1_i,
    output logic cnt0_o,
    output logic cnt1_o,
    output logic gate0_o,
    output logic gate1_o
);
    logic [1:0] src = 2'b11;
    logic [1:0] gate = 2'b11;
    // wire level from the block's output enable; the external source has none
    assign cnt0_o = oe0_i ? drv0_i : src[0];
    assign cnt1_o = oe1_i ? drv1_i : src[1];
    assign gate0_o = gate[0];
    assign gate1_o = gate[1];
    // each level held hold cycles, so a slow sampler never misses one
    task automatic pulse(input logic w, input int n, input int hold);
        repeat (n)
        begin
            repeat (hold) @(posedge clk_i);
            src[w] <= 1'b0;
            repeat (hold) @(posedge clk_i);
            src[w] <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

/* dtc_sync.v */
// Purpose: two-flop synchroniser for a level input
// Assumes: input is asynchronous to clk_i
// Notes: first flop read only by the second
`timescale 1ns/1ps
`default_nettype none
module dtc_sync
(
    input wire clk_i,
    input wire rst_i,
    input wire d_i,
    output reg q_o
);
    reg meta_q;
    // plain double flop
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* dtc_top.v */
// Functional notes
// - timer function adds one per peripheral clock while enabled.
// - counter function samples pin each machine cycle, counts 1-to-0.
// - new count shows in the machine cycle after detection.
// - edge recognition takes two machine cycles, max rate quarter clock.
// - function bit 2/6 picks internal clock or external pin.
// - gate bit 3/7 also needs gate pin high to count.
// - mode is aux bit plus two mode bits per timer.
// - mode 000 uses low byte as 5-bit prescaler.
// - mode 001 cascades both bytes into 16 bits.
// - mode 010 reloads low byte from high byte on overflow.
// - mode 011 splits timer 0; high byte uses timer 1 run/flag.
// - optional toggle of count pin on each overflow.
// - mode 0 is 13 bits; rollover sets overflow flag.
// - run bits 4 and 6 of control register enable counting.
// - pwm period 256 clocks, low phase from high byte.
// - setting run bit keeps current count.
//
// Purpose: two timer/counters behind a classic wishbone slave
// Assumes: peripheral clock tick = clk_i, machine cycle = two clocks
// Notes: one-cycle ack, reads of status clear it
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defines.vh"
module dtc_top
(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire gate_pin_0_i,
    input wire gate_pin_1_i,
    input wire count_pin_0_i,
    input wire count_pin_1_i,
    output reg count_pin_0_o,
    output reg count_pin_0_oe_o,
    output reg count_pin_1_o,
    output reg count_pin_1_oe_o,
    output reg irq_o
);
    //--------------------------------------------------
    // registers and wires
    //--------------------------------------------------
    reg [7:0] mode_q;
    reg [7:0] aux_q;
    reg [7:0] ctrl_q;
    reg [7:0] tl_q [0:1];
    reg [7:0] th_q [0:1];
    reg [1:0] tog_en_q;
    reg [1:0] istat_q;
    reg [1:0] imask_q;
    reg mc_q;
    wire [1:0] gate_s;
    wire [1:0] fall_s;
    // mode code for one timer: aux bit above the two mode bits
    function [2:0] mode_of;
        input aux_bit;
        input [1:0] pair;
        begin
            mode_of = {aux_bit, pair};
        end
    endfunction
    wire [2:0] mode0 = mode_of(aux_q[`DTC_T0_MODE_B2],
        mode_q[`DTC_T0_MODE_LO+1 -: 2]);
    wire [2:0] mode1 = mode_of(aux_q[`DTC_T1_MODE_B2],
        mode_q[`DTC_T1_MODE_LO+1 -: 2]);
    wire t0_split = (mode0 == `DTC_MODE_SPLIT);

    // word index from byte address
    wire [7:0] idx = wb_adr_i[9:2];
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i & wb_sel_i[0];
    wire rd = req & ~wb_we_i;

    //--------------------------------------------------
    // pin synchronisers and edge detectors
    //--------------------------------------------------
    // one gate synchroniser and one count-edge detector per timer
    wire [1:0] gate_raw = {gate_pin_1_i, gate_pin_0_i};
    wire [1:0] cnt_raw = {count_pin_1_i, count_pin_0_i};
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_pin
            dtc_sync u_gs (.clk_i(clk_i), .rst_i(rst_i), .d_i(gate_raw[g]),
                .q_o(gate_s[g]));
            dtc_edge_det u_ed (.clk_i(clk_i), .rst_i(rst_i), .pin_i(cnt_raw[g]),
                .mc_tick_i(mc_q), .fall_o(fall_s[g]));
        end
    endgenerate

    // machine cycle strobe, every second clock
    always @(posedge clk_i)
    begin
        if (rst_i)
            mc_q <= 1'b0;
        else
            mc_q <= ~mc_q;
    end

    //--------------------------------------------------
    // per-timer count enables
    //--------------------------------------------------
    // decode the run/gate/func enable for one timer
    function cnt_en;
        input run;
        input gate_en;
        input gate_lvl;
        input func;
        input fall;
        begin
            // gated run, then clock or pin edge
            cnt_en = run & (~gate_en | gate_lvl) & (func ? fall : 1'b1);
        end
    endfunction

    wire t0_inc = cnt_en(ctrl_q[`DTC_T0_RUN], mode_q[`DTC_T0_GATE], gate_s[0],
        mode_q[`DTC_T0_FUNC], fall_s[0]);
    wire t1_inc = cnt_en(ctrl_q[`DTC_T1_RUN], mode_q[`DTC_T1_GATE], gate_s[1],
        mode_q[`DTC_T1_FUNC], fall_s[1]) & (mode1 != `DTC_MODE_SPLIT);
    // split high byte: internal clock, timer 1 run only
    wire th0_split_inc = t0_split & ctrl_q[`DTC_T1_RUN];

    //--------------------------------------------------
    // counter next-state
    //--------------------------------------------------
    reg [7:0] tl_d [0:1];
    reg [7:0] th_d [0:1];
    reg [1:0] ovf_d;
    reg ovf_th0;
    reg [1:0] pwm_d;
    reg [1:0] pwm_q;
    integer n;
    always @*
    begin
        ovf_th0 = 1'b0;
        for (n = 0; n < 2; n = n + 1)
        begin
            tl_d[n] = tl_q[n];
            th_d[n] = th_q[n];
            ovf_d[n] = 1'b0;
            pwm_d[n] = pwm_q[n];
            if (n == 0 ? t0_inc : t1_inc)
            begin
                case (n == 0 ? mode0 : mode1)
                `DTC_MODE_13:
                begin
                    // 13 bits; upper low-byte bits held at zero
                    tl_d[n] = {3'h0, tl_q[n][4:0] + 5'h01};
                    if (tl_q[n][4:0] == 5'h1f)
                    begin
                        th_d[n] = th_q[n] + 8'h01;
                        ovf_d[n] = (th_q[n] == 8'hff);
                    end
                end
                `DTC_MODE_16:
                begin
                    {th_d[n], tl_d[n]} = {th_q[n], tl_q[n]} + 16'h0001;
                    ovf_d[n] = ({th_q[n], tl_q[n]} == 16'hffff);
                end
                `DTC_MODE_RELOAD:
                begin
                    tl_d[n] = (tl_q[n] == 8'hff) ? th_q[n] : tl_q[n] + 8'h01;
                    ovf_d[n] = (tl_q[n] == 8'hff);
                end
                `DTC_MODE_SPLIT:
                begin
                    // timer 1 never gets here; timer 0 low byte only
                    tl_d[n] = tl_q[n] + 8'h01;
                    ovf_d[n] = (tl_q[n] == 8'hff);
                end
                `DTC_MODE_PWM:
                begin
                    // 256-clock period, low phase of th clocks, whole period low when th is 8'hff
                    tl_d[n] = tl_q[n] + 8'h01;
                    ovf_d[n] = (tl_q[n] == 8'hff);
                    pwm_d[n] = (th_q[n] == 8'h00) ? 1'b1 :
                        (th_q[n] == 8'hff) ? 1'b0 :
                        (tl_d[n] >= th_q[n]);
                end
                default:
                begin
                    // reserved codes hold the count
                    tl_d[n] = tl_q[n];
                end
                endcase
            end
        end
        if (th0_split_inc)
        begin
            th_d[0] = th_q[0] + 8'h01;
            ovf_th0 = (th_q[0] == 8'hff);
        end
    end

    //--------------------------------------------------
    // flags, interrupt status, toggle pins
    //--------------------------------------------------
    // overflow flag events per timer; split mode moves th0 onto timer 1
    wire [1:0] flag_set = {ovf_d[1] | ovf_th0, ovf_d[0]};

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= `DTC_RST_BYTE;
            aux_q <= `DTC_RST_BYTE;
            ctrl_q <= `DTC_RST_BYTE;
            tl_q[0] <= `DTC_RST_BYTE;
            tl_q[1] <= `DTC_RST_BYTE;
            th_q[0] <= `DTC_RST_BYTE;
            th_q[1] <= `DTC_RST_BYTE;
            tog_en_q <= 2'h0;
            istat_q <= 2'h0;
            imask_q <= 2'h0;
            pwm_q <= 2'h3;
            count_pin_0_o <= 1'b1;
            count_pin_1_o <= 1'b1;
            count_pin_0_oe_o <= 1'b0;
            count_pin_1_oe_o <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
            // counters; new value lands the cycle after edge detection
            tl_q[0] <= tl_d[0];
            tl_q[1] <= tl_d[1];
            th_q[0] <= th_d[0];
            th_q[1] <= th_d[1];
            pwm_q <= pwm_d;
            if (wr)
            begin
                case (idx)
                `DTC_IDX_MODE: mode_q <= wb_dat_i[7:0];
                `DTC_IDX_AUX: aux_q <= wb_dat_i[7:0] & `DTC_AUX_MASK;
                `DTC_IDX_TL0: tl_q[0] <= wb_dat_i[7:0];
                `DTC_IDX_TL1: tl_q[1] <= wb_dat_i[7:0];
                `DTC_IDX_TH0: th_q[0] <= wb_dat_i[7:0];
                `DTC_IDX_TH1: th_q[1] <= wb_dat_i[7:0];
                `DTC_IDX_TOG: tog_en_q <= wb_dat_i[1:0];
                `DTC_IDX_IMASK: imask_q <= wb_dat_i[1:0];
                default: ;
                endcase
            end
            // control: software write first, hardware set wins
            if (wr && idx == `DTC_IDX_CTRL)
                ctrl_q <= wb_dat_i[7:0];
            if (flag_set[0])
                ctrl_q[`DTC_T0_FLAG] <= 1'b1;
            if (flag_set[1])
                ctrl_q[`DTC_T1_FLAG] <= 1'b1;
            // pwm: flag follows the waveform, low phase = flag set
            if (mode0 == `DTC_MODE_PWM)
                ctrl_q[`DTC_T0_FLAG] <= ~pwm_d[0];
            if (mode1 == `DTC_MODE_PWM)
                ctrl_q[`DTC_T1_FLAG] <= ~pwm_d[1];
            // sticky status cleared by read; set beats clear
            istat_q <= ((rd && idx == `DTC_IDX_ISTAT) ? 2'h0 : istat_q) | flag_set;
            irq_o <= |(istat_q & imask_q);
            // toggle output, only with internal clock source
            count_pin_0_oe_o <= (tog_en_q[0] & ~mode_q[`DTC_T0_FUNC]) | (mode0 == `DTC_MODE_PWM);
            count_pin_1_oe_o <= (tog_en_q[1] & ~mode_q[`DTC_T1_FUNC]) | (mode1 == `DTC_MODE_PWM);
            if (mode0 == `DTC_MODE_PWM)
                count_pin_0_o <= pwm_d[0];
            else if (!tog_en_q[0])
                count_pin_0_o <= 1'b1;
            else if (flag_set[0])
                count_pin_0_o <= ~count_pin_0_o;
            if (mode1 == `DTC_MODE_PWM)
                count_pin_1_o <= pwm_d[1];
            else if (!tog_en_q[1])
                count_pin_1_o <= 1'b1;
            else if (flag_set[1])
                count_pin_1_o <= ~count_pin_1_o;
            // read mux
            wb_dat_o <= 32'h0;
            if (rd)
            begin
                case (idx)
                `DTC_IDX_CTRL: wb_dat_o[7:0] <= ctrl_q;
                `DTC_IDX_MODE: wb_dat_o[7:0] <= mode_q;
                `DTC_IDX_AUX: wb_dat_o[7:0] <= aux_q;
                `DTC_IDX_TL0: wb_dat_o[7:0] <= tl_q[0];
                `DTC_IDX_TL1: wb_dat_o[7:0] <= tl_q[1];
                `DTC_IDX_TH0: wb_dat_o[7:0] <= th_q[0];
                `DTC_IDX_TH1: wb_dat_o[7:0] <= th_q[1];
                `DTC_IDX_TOG: wb_dat_o[1:0] <= tog_en_q;
                `DTC_IDX_ISTAT: wb_dat_o[1:0] <= istat_q;
                `DTC_IDX_IMASK: wb_dat_o[1:0] <= imask_q;
                default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* dtc_top_sva.sv */
// Purpose: port checks for dtc_top
// Assumes: one-cycle ack, byte data in bits 7:0
// Notes: shadows track mode and mask writes
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defines.vh"
module dtc_top_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] mode_q;
    logic [1:0] mask_q;
    wire [7:0] idx = wb_adr_i[9:2];
    wire wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire rd_ok = wb_ack_o && !wb_we_i;
    // ----------
    // shadows
    // ----------
    // taken at the ack edge, one edge after the slave applies a write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= 8'h00;
            mask_q <= 2'h0;
        end
        else if (wr_ok && idx == `DTC_IDX_MODE)
            mode_q <= wb_dat_i[7:0];
        else if (wr_ok && idx == `DTC_IDX_IMASK)
            mask_q <= wb_dat_i[1:0];
    end
    // ----------
    // properties
    // ----------
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    unmapped_zero_a: assert property (rd_ok && idx == 8'h90 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    aux_resv_a:
        assert property (rd_ok && idx == `DTC_IDX_AUX |-> (wb_dat_o[7:0] & 8'hee) == 8'h00)
        else $error("reserved aux bits read back");
    mode_back_a:
        assert property (rd_ok && idx == `DTC_IDX_MODE |-> wb_dat_o[7:0] == mode_q)
        else $error("mode register readback wrong");
    irq_mask_a: assert property (irq_o |-> mask_q != 2'h0)
        else $error("irq while all masked");
    cover property (wr_ok && idx == `DTC_IDX_MODE);
    cover property (irq_o);
    cover property (rd_ok && idx == `DTC_IDX_AUX);
endmodule
`default_nettype wire

/* tb_dtc_top.sv */
// Purpose: self-checking bench for dtc_top
// Assumes: one-cycle ack, one count per clock in timer function
// Notes: reads three cycles apart give exact count deltas
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defines.vh"
module tb_dtc_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire ack, irq, p0_o, p0_oe, p1_o, p1_oe, c0, c1, g0, g1;
    int n_mismatch = 0;
    int n_tests = 0;
    int k;
    logic [7:0] x, y, z;
    always #2.5 clk_i = ~clk_i;
    dtc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .gate_pin_0_i(g0), .gate_pin_1_i(g1), .count_pin_0_i(c0),
        .count_pin_1_i(c1), .count_pin_0_o(p0_o), .count_pin_0_oe_o(p0_oe),
        .count_pin_1_o(p1_o), .count_pin_1_oe_o(p1_oe), .irq_o(irq));
    dtc_pins pins_u (.clk_i(clk_i), .drv0_i(p0_o), .oe0_i(p0_oe), .drv1_i(p1_o),
        .oe1_i(p1_oe), .cnt0_o(c0), .cnt1_o(c1), .gate0_o(g0), .gate1_o(g1));
    // ----------
    // bus tasks
    // ----------
    // request held until ack is sampled, data taken at that edge
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        // no cycle limit here: a missing ack is left to the watchdog
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        q = rdat[7:0];
        req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] t;
        xfer(1'b1, i, d, t);
    endtask
    task automatic rd(input logic [7:0] i, output logic [7:0] q);
        xfer(1'b0, i, 8'h00, q);
    endtask
    task automatic meas(input logic [7:0] a, input logic [7:0] b);
        rd(a, x);
        rd(b, y);
        rd(a, z);
    endtask
    // stop first so the loads land on a still counter
    task automatic setup(input logic [7:0] m, a, tl, th, c);
        wr(`DTC_IDX_CTRL, 8'h00);
        wr(`DTC_IDX_TL0, tl);
        wr(`DTC_IDX_TH0, th);
        wr(`DTC_IDX_AUX, a);
        wr(`DTC_IDX_MODE, m);
        wr(`DTC_IDX_CTRL, c);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // cycles between two changes of the count pin 0 drive
    task automatic gap(output int n);
        logic p;
        repeat (2)
        begin
            p = p0_o;
            n = 0;
            while (p0_o === p && n < 40)
            begin
                @(posedge clk_i);
                n++;
            end
        end
    endtask
    task automatic conclude;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
    // ----------
    // tests
    // ----------
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`DTC_IDX_MODE, x);
        chk(x, 8'h00);
        rd(`DTC_IDX_CTRL, x);
        chk(x, 8'h00);
        rd(8'h90, x);
        chk(x, 8'h00);
        wr(`DTC_IDX_AUX, 8'hff);
        rd(`DTC_IDX_AUX, x);
        chk(x, 8'h11);
        // counter function, timer 1 at the top rate
        setup(8'h55, 8'h00, 8'h00, 8'h00, 8'h50);
        pins_u.pulse(1'b0, 5, 4);
        pins_u.pulse(1'b1, 3, 2);
        repeat (8) @(posedge clk_i);
        rd(`DTC_IDX_TL0, x);
        chk(x, 8'h05);
        rd(`DTC_IDX_TL1, x);
        chk(x, 8'h03);
        setup(8'h01, 8'h00, 8'hf8, 8'h12, 8'h10);
        meas(`DTC_IDX_TL0, `DTC_IDX_TH0);
        chk(x & 8'hf8, 8'hf8);
        chk(z, x + 8'h06);
        chk(y, (x > 8'hfc) ? 8'h13 : 8'h12);
        setup(8'h00, 8'h00, 8'h1c, 8'hff, 8'h10);
        meas(`DTC_IDX_TL0, `DTC_IDX_TH0);
        chk(x & 8'he0, 8'h00);
        chk(z, (x + 8'h06) & 8'h1f);
        rd(`DTC_IDX_TH0, y);
        chk(y, 8'h00);
        rd(`DTC_IDX_CTRL, y);
        chk(y & 8'h30, 8'h30);
        setup(8'h02, 8'h00, 8'hfe, 8'h80, 8'h10);
        repeat (8) @(posedge clk_i);
        meas(`DTC_IDX_TL0, `DTC_IDX_TH0);
        chk(x & 8'h80, 8'h80);
        chk(y, 8'h80);
        chk(z, x + 8'h06);
        // sticky status, mask and read-to-clear
        wr(`DTC_IDX_CTRL, 8'h00);
        wr(`DTC_IDX_IMASK, 8'h01);
        repeat (2) @(posedge clk_i);
        chk({7'h0, irq}, 8'h01);
        wr(`DTC_IDX_IMASK, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({7'h0, irq}, 8'h00);
        wr(`DTC_IDX_IMASK, 8'h01);
        rd(`DTC_IDX_ISTAT, x);
        chk(x, 8'h01);
        repeat (2) @(posedge clk_i);
        chk({7'h0, irq}, 8'h00);
        rd(`DTC_IDX_ISTAT, x);
        chk(x, 8'h00);
        // gate low holds the count, gate high releases it
        pins_u.gate[0] <= 1'b0;
        setup(8'h09, 8'h00, 8'h00, 8'h00, 8'h10);
        meas(`DTC_IDX_TL0, `DTC_IDX_TL0);
        chk(z, x);
        pins_u.gate[0] <= 1'b1;
        repeat (4) @(posedge clk_i);
        meas(`DTC_IDX_TL0, `DTC_IDX_TL0);
        chk(z, x + 8'h06);
        setup(8'h33, 8'h00, 8'h00, 8'h00, 8'h40);
        meas(`DTC_IDX_TH0, `DTC_IDX_TL0);
        chk(z, x + 8'h06);
        chk(y, 8'h00);
        meas(`DTC_IDX_TL1, `DTC_IDX_TL1);
        chk(z, x);
        wr(`DTC_IDX_TOG, 8'h01);
        setup(8'h02, 8'h00, 8'hf0, 8'hf0, 8'h10);
        gap(k);
        chk(k[7:0], 8'h10);
        chk({7'h0, p0_oe}, 8'h01);
        // only the legal pwm code 110 is written here; aux 8'hff earlier set reserved code 100
        wr(`DTC_IDX_TOG, 8'h00);
        setup(8'h02, 8'h01, 8'h00, 8'hff, 8'h10);
        repeat (4) @(posedge clk_i);
        chk({6'h0, p0_oe, p0_o}, 8'h02);
        wr(`DTC_IDX_TH0, 8'h00);
        repeat (4) @(posedge clk_i);
        chk({6'h0, p0_oe, p0_o}, 8'h03);
        chk({6'h0, p1_oe, p1_o}, 8'h01);
        conclude();
    end
endmodule
bind dtc_top dtc_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire
